/* rtl/alu_flag_pkg.sv */
// Purpose: shared constants, types and carriers for the status flag block
// Assumes: 32-bit integer datapath, 30-bit word program counter
// Notes:   byte offsets are for a 32-bit Avalon-MM slave
package alu_flag_pkg;

   // ==========
   // widths
   localparam int WORD_W = 32;
   localparam int PC_W = 30;
   localparam int OPC_W = 8;
   localparam int ADDR_W = 5;
   localparam int FP_EXC_W = 6;

   // ==========
   // register byte offsets
   localparam logic [ADDR_W-1:0] ALU_STATUS_OFS = 5'h00;
   localparam logic [ADDR_W-1:0] CONTROL_OFS = 5'h04;
   localparam logic [ADDR_W-1:0] FP_ENV_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] FP_STATUS_OFS = 5'h0C;
   localparam logic [ADDR_W-1:0] PC2_OFS = 5'h10;
   localparam logic [ADDR_W-1:0] EXC_OPCODE_OFS = 5'h14;

   // ==========
   // field positions
   localparam int CARRY_POS = 0;
   localparam int ZERO_POS = 1;
   localparam int NEG_POS = 2;
   localparam int OVF_POS = 3;
   localparam int FREEZE_POS = 0;
   localparam int MUL_MASK_POS = 1;
   localparam int STICKY_LSB = 0;
   localparam int TRAP_LSB = 8;

   // fp exception bit order inside a six-bit vector
   localparam int FP_DIVZ = 0;
   localparam int FP_INEXACT = 1;
   localparam int FP_UNDER = 2;
   localparam int FP_OVER = 3;
   localparam int FP_RESV = 4;
   localparam int FP_INVALID = 5;

   // ==========
   // reset values
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   localparam logic [FP_EXC_W-1:0] FP_MASK_RESET = 6'h00;
   localparam logic [FP_EXC_W-1:0] FP_BITS_RESET = 6'h00;

   // ==========
   // enumerations
   typedef enum logic [1:0] {
      CLASS_NONE, CLASS_ARITH, CLASS_LOGICAL, CLASS_MULDIV
   } op_class_type;

   typedef enum logic [1:0] {
      CHECK_NONE, CHECK_SIGNED, CHECK_UNS_ADD, CHECK_UNS_SUB
   } range_check_type;

   typedef enum logic [2:0] {
      signed_mul_op, unsigned_mul_op, signed_mulm_op,
      unsigned_mulm_op, signed_div_op, unsigned_div_op
   } muldiv_op_type;

   typedef enum logic [1:0] {
      BUS_IDLE, BUS_ANSWER
   } bus_state_type;

   // ==========
   // carriers
   typedef struct packed {
      logic ovf;
      logic neg;
      logic zero;
      logic carry;
   } alu_flags_type;

   typedef struct packed {
      logic valid;
      op_class_type op_class;
      range_check_type check;
      muldiv_op_type muldiv_op;
      logic mul_overflow;
      logic [WORD_W-1:0] add_a;
      logic [WORD_W-1:0] add_b;
      logic add_cin;
      logic use_shift;
      logic [WORD_W-1:0] shifted_result;
      logic [WORD_W-1:0] logic_result;
      logic [PC_W-1:0] pc;
      logic [OPC_W-1:0] opcode;
   } exec_type;

   typedef struct packed {
      logic valid;
      logic is_divide;
      logic divisor_zero;
      logic dividend_nonzero_finite;
      logic inexact;
      logic too_small;
      logic too_large;
      logic reserved_input;
      logic reserved_result;
      logic indeterminate;
   } fp_event_type;

endpackage : alu_flag_pkg

/* rtl/alu_status_flag_logic.sv */
// Purpose: integer ALU status flags, range trap cause, fp status policy
// Assumes: exec inputs arrive in the writeback cycle of the instruction
// Notes:   registers reached over Avalon-MM with waitrequest
`timescale 1ns/100ps

// Notes on behaviour
// - overflow when msb carry-in differs carry-out
// - signed overflow rule even for unsigned adds
// - negative from raw adder msb
// - zero from written word, post-shift
// - carry from adder top carry out
// - subtraction is add of complement
// - only arithmetic, logical, explicit writes update
// - freeze blocks all but explicit writes
// - full-word multiply, divide leave flags alone
// - unmasked mul (not mulm) overflow raises range trap
// - arith range trap still writes result; any range trap saves pc
// - flags encode arith range trap cause unless frozen
// - logical keeps overflow and carry
// - logical sets negative and zero
// - only carry and negative are consumed
// - masked fp exception sets sticky bit
// - fp trap rewrites all trap bits
// - sticky bits cleared only by software
// - divide by zero: zero divisor, nonzero finite dividend
// - inexact, underflow, overflow detection
// - reserved operand and invalid operation
module alu_status_flag_logic (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [alu_flag_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [alu_flag_pkg::WORD_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [alu_flag_pkg::WORD_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire alu_flag_pkg::exec_type exec_in,
   input wire alu_flag_pkg::fp_event_type fp_in,
   output alu_flag_pkg::alu_flags_type flags_out,
   output logic wb_valid,
   output logic [alu_flag_pkg::WORD_W-1:0] wb_data,
   output logic range_trap,
   output logic [alu_flag_pkg::PC_W-1:0] pc2,
   output logic fp_trap
);

   // ==========
   // helpers
   function automatic logic [3:0] lane_merge(
      input logic [3:0] old_val,
      input logic [3:0] new_val,
      input logic lane0
   );
      lane_merge = lane0 ? new_val : old_val;
   endfunction : lane_merge

   function automatic logic [5:0] byte_merge(
      input logic [5:0] old_val,
      input logic [5:0] new_val,
      input logic lane
   );
      byte_merge = lane ? new_val : old_val;
   endfunction : byte_merge

   // ==========
   // state
   alu_flag_pkg::alu_flags_type flags_reg;
   alu_flag_pkg::alu_flags_type flags_next;
   logic freeze_reg;
   logic mul_mask_reg;
   logic [alu_flag_pkg::FP_EXC_W-1:0] fp_mask_reg;
   logic [alu_flag_pkg::FP_EXC_W-1:0] sticky_reg;
   logic [alu_flag_pkg::FP_EXC_W-1:0] sticky_next;
   logic [alu_flag_pkg::FP_EXC_W-1:0] trap_bits_reg;
   logic [alu_flag_pkg::FP_EXC_W-1:0] trap_bits_next;
   logic [alu_flag_pkg::PC_W-1:0] pc2_reg;
   logic [alu_flag_pkg::OPC_W-1:0] exc_opcode_reg;
   logic range_trap_reg;
   logic fp_trap_reg;
   logic wb_valid_reg;
   logic [alu_flag_pkg::WORD_W-1:0] wb_data_reg;
   logic [alu_flag_pkg::WORD_W-1:0] readdata_reg;
   logic waitrequest_reg;
   alu_flag_pkg::bus_state_type bus_state_reg;

   // ==========
   // bus decode
   logic bus_take_write;
   logic bus_start_read;
   logic wr_status;
   logic wr_control;
   logic wr_fp_env;
   logic wr_fp_status;

   always_comb begin
      bus_take_write = avs_write && (bus_state_reg == alu_flag_pkg::BUS_ANSWER);
      bus_start_read = avs_read && (bus_state_reg == alu_flag_pkg::BUS_IDLE);
      wr_status = bus_take_write &&
         (avs_address == alu_flag_pkg::ALU_STATUS_OFS);
      wr_control = bus_take_write &&
         (avs_address == alu_flag_pkg::CONTROL_OFS);
      wr_fp_env = bus_take_write &&
         (avs_address == alu_flag_pkg::FP_ENV_OFS);
      wr_fp_status = bus_take_write &&
         (avs_address == alu_flag_pkg::FP_STATUS_OFS);
   end

   // ==========
   // integer adder and flag terms
   logic [alu_flag_pkg::WORD_W:0] add_sum;
   logic carry_out;
   logic carry_into_msb;
   logic add_ovf;
   logic [alu_flag_pkg::WORD_W-1:0] arith_word;
   logic is_arith;
   logic is_logical;
   logic is_mul_trap;
   logic arith_range;

   always_comb begin
      // operands already complemented for subtract and step ops
      add_sum = {1'b0, exec_in.add_a} + {1'b0, exec_in.add_b} +
         {{alu_flag_pkg::WORD_W{1'b0}}, exec_in.add_cin};
      carry_out = add_sum[alu_flag_pkg::WORD_W];
      carry_into_msb = exec_in.add_a[alu_flag_pkg::WORD_W-1] ^
         exec_in.add_b[alu_flag_pkg::WORD_W-1] ^
         add_sum[alu_flag_pkg::WORD_W-1];
      add_ovf = carry_into_msb ^ carry_out;
      arith_word = exec_in.use_shift ? exec_in.shifted_result
         : add_sum[alu_flag_pkg::WORD_W-1:0];
      is_arith = exec_in.valid &&
         (exec_in.op_class == alu_flag_pkg::CLASS_ARITH);
      is_logical = exec_in.valid &&
         (exec_in.op_class == alu_flag_pkg::CLASS_LOGICAL);
      is_mul_trap = exec_in.valid &&
         (exec_in.op_class == alu_flag_pkg::CLASS_MULDIV) &&
         ((exec_in.muldiv_op == alu_flag_pkg::signed_mul_op) ||
          (exec_in.muldiv_op == alu_flag_pkg::unsigned_mul_op)) &&
         exec_in.mul_overflow && !mul_mask_reg;
      case (exec_in.check)
         alu_flag_pkg::CHECK_SIGNED: arith_range = add_ovf;
         alu_flag_pkg::CHECK_UNS_ADD: arith_range = carry_out;
         alu_flag_pkg::CHECK_UNS_SUB: arith_range = !carry_out;
         default: arith_range = 1'b0;
      endcase
   end

   // ==========
   // next flag value
   always_comb begin
      flags_next = flags_reg;
      if (wr_status && avs_byteenable[0]) begin
         // explicit register write is honoured even while frozen
         flags_next = lane_merge(flags_reg, avs_writedata[3:0], 1'b1);
      end else if (!freeze_reg) begin
         if (is_arith) begin
            flags_next.ovf = add_ovf;
            flags_next.neg = add_sum[alu_flag_pkg::WORD_W-1];
            flags_next.zero = (arith_word == '0);
            flags_next.carry = carry_out;
         end else if (is_logical) begin
            flags_next.neg =
               exec_in.logic_result[alu_flag_pkg::WORD_W-1];
            flags_next.zero = (exec_in.logic_result == '0);
            // overflow and carry keep their value
         end
         // multiply/divide and other classes leave flags
      end
   end

   // ==========
   // alu status register, written at the writeback edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_reg <= alu_flag_pkg::FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // ==========
   // writeback word and range trap
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_valid_reg <= 1'b0;
         wb_data_reg <= '0;
      end else begin
         // written even when the instruction traps
         wb_valid_reg <= is_arith || is_logical;
         wb_data_reg <= is_logical ? exec_in.logic_result : arith_word;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         range_trap_reg <= 1'b0;
         pc2_reg <= '0;
         exc_opcode_reg <= '0;
      end else begin
         range_trap_reg <= (is_arith && arith_range) || is_mul_trap;
         if ((is_arith && arith_range) || is_mul_trap) begin
            pc2_reg <= exec_in.pc;
            exc_opcode_reg <= exec_in.opcode;
         end
      end
   end

   // ==========
   // control registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         freeze_reg <= alu_flag_pkg::CONTROL_RESET[alu_flag_pkg::FREEZE_POS];
         mul_mask_reg <=
            alu_flag_pkg::CONTROL_RESET[alu_flag_pkg::MUL_MASK_POS];
         fp_mask_reg <= alu_flag_pkg::FP_MASK_RESET;
      end else begin
         if (wr_control && avs_byteenable[0]) begin
            freeze_reg <= avs_writedata[alu_flag_pkg::FREEZE_POS];
            mul_mask_reg <= avs_writedata[alu_flag_pkg::MUL_MASK_POS];
         end
         if (wr_fp_env) begin
            fp_mask_reg <= byte_merge(fp_mask_reg,
               avs_writedata[alu_flag_pkg::FP_EXC_W-1:0],
               avs_byteenable[0]);
         end
      end
   end

   // ==========
   // floating-point exception detection
   logic [alu_flag_pkg::FP_EXC_W-1:0] fp_exc;
   logic fp_trap_now;

   always_comb begin
      fp_exc = '0;
      if (fp_in.valid) begin
         fp_exc[alu_flag_pkg::FP_DIVZ] = fp_in.is_divide &&
            fp_in.divisor_zero && fp_in.dividend_nonzero_finite;
         fp_exc[alu_flag_pkg::FP_INEXACT] = fp_in.inexact;
         fp_exc[alu_flag_pkg::FP_UNDER] = fp_in.too_small;
         fp_exc[alu_flag_pkg::FP_OVER] = fp_in.too_large;
         fp_exc[alu_flag_pkg::FP_RESV] =
            fp_in.reserved_input || fp_in.reserved_result;
         fp_exc[alu_flag_pkg::FP_INVALID] = fp_in.indeterminate;
      end
      // any unmasked exception traps
      fp_trap_now = |(fp_exc & ~fp_mask_reg);
   end

   always_comb begin
      sticky_next = sticky_reg;
      trap_bits_next = trap_bits_reg;
      if (wr_fp_status) begin
         // software write is the only way sticky bits fall
         sticky_next = byte_merge(sticky_reg,
            avs_writedata[alu_flag_pkg::STICKY_LSB +:
               alu_flag_pkg::FP_EXC_W], avs_byteenable[0]);
         trap_bits_next = byte_merge(trap_bits_reg,
            avs_writedata[alu_flag_pkg::TRAP_LSB +:
               alu_flag_pkg::FP_EXC_W], avs_byteenable[1]);
      end
      // hardware sets win over a same-cycle software clear
      sticky_next = sticky_next | (fp_exc & fp_mask_reg);
      if (fp_trap_now) begin
         trap_bits_next = fp_exc;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sticky_reg <= alu_flag_pkg::FP_BITS_RESET;
         trap_bits_reg <= alu_flag_pkg::FP_BITS_RESET;
         fp_trap_reg <= 1'b0;
      end else begin
         sticky_reg <= sticky_next;
         trap_bits_reg <= trap_bits_next;
         fp_trap_reg <= fp_trap_now;
      end
   end

   // ==========
   // avalon slave: one wait cycle, then answer
   logic [alu_flag_pkg::WORD_W-1:0] read_mux;

   always_comb begin
      read_mux = '0;
      case (avs_address)
         alu_flag_pkg::ALU_STATUS_OFS: read_mux[3:0] = flags_reg;
         alu_flag_pkg::CONTROL_OFS: begin
            read_mux[alu_flag_pkg::FREEZE_POS] = freeze_reg;
            read_mux[alu_flag_pkg::MUL_MASK_POS] = mul_mask_reg;
         end
         alu_flag_pkg::FP_ENV_OFS:
            read_mux[alu_flag_pkg::FP_EXC_W-1:0] = fp_mask_reg;
         alu_flag_pkg::FP_STATUS_OFS: begin
            read_mux[alu_flag_pkg::STICKY_LSB +: alu_flag_pkg::FP_EXC_W] =
               sticky_reg;
            read_mux[alu_flag_pkg::TRAP_LSB +: alu_flag_pkg::FP_EXC_W] =
               trap_bits_reg;
         end
         alu_flag_pkg::PC2_OFS: read_mux[alu_flag_pkg::PC_W-1:0] = pc2_reg;
         alu_flag_pkg::EXC_OPCODE_OFS:
            read_mux[alu_flag_pkg::OPC_W-1:0] = exc_opcode_reg;
         default: read_mux = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus_state_reg <= alu_flag_pkg::BUS_IDLE;
         waitrequest_reg <= 1'b1;
         readdata_reg <= '0;
      end else begin
         case (bus_state_reg)
            alu_flag_pkg::BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state_reg <= alu_flag_pkg::BUS_ANSWER;
                  waitrequest_reg <= 1'b0;
               end
               if (bus_start_read) begin
                  readdata_reg <= read_mux;
               end
            end
            alu_flag_pkg::BUS_ANSWER: begin
               bus_state_reg <= alu_flag_pkg::BUS_IDLE;
               waitrequest_reg <= 1'b1;
            end
            default: begin
               bus_state_reg <= alu_flag_pkg::BUS_IDLE;
               waitrequest_reg <= 1'b1;
            end
         endcase
      end
   end

   // ==========
   // outputs
   always_comb begin
      avs_readdata = readdata_reg;
      avs_waitrequest = waitrequest_reg;
      flags_out = flags_reg;     // carry and negative feed execution
      wb_valid = wb_valid_reg;
      wb_data = wb_data_reg;
      range_trap = range_trap_reg;
      pc2 = pc2_reg;
      fp_trap = fp_trap_reg;
   end

endmodule : alu_status_flag_logic

/* verification/alu_status_flag_checker.sv */
// Purpose: port-level checks of the status flag block
// Assumes: one clock, synchronous active-high reset
// Notes:   control and fp mask bits shadowed from bus writes
`timescale 1ns/100ps
module alu_status_flag_checker (
   input logic core_clk,
   input logic rst,
   input logic [alu_flag_pkg::ADDR_W-1:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [alu_flag_pkg::WORD_W-1:0] avs_writedata,
   input logic [3:0] avs_byteenable,
   input logic avs_waitrequest,
   input alu_flag_pkg::exec_type exec_in,
   input alu_flag_pkg::fp_event_type fp_in,
   input alu_flag_pkg::alu_flags_type flags_out,
   input logic wb_valid,
   input logic [alu_flag_pkg::WORD_W-1:0] wb_data,
   input logic range_trap,
   input logic [alu_flag_pkg::PC_W-1:0] pc2,
   input logic fp_trap
);
   // ==========
   // shadow state and expectations
   logic freeze_reg, mask_reg, wr_ok, alu_wr, ovf, trap_exp, fp_hit;
   logic [5:0] fmask_reg, fexc;
   logic [32:0] sum;
   logic [31:0] word, lres;
   logic [1:0] cls;
   alu_flag_pkg::alu_flags_type a_exp, l_exp;
   assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign alu_wr = wr_ok && avs_address == alu_flag_pkg::ALU_STATUS_OFS;
   assign cls = exec_in.valid ? exec_in.op_class : 2'h0;
   assign sum = {1'b0, exec_in.add_a} + {1'b0, exec_in.add_b}
      + 33'(exec_in.add_cin);
   assign word = exec_in.use_shift ? exec_in.shifted_result : sum[31:0];
   assign ovf = exec_in.add_a[31] == exec_in.add_b[31]
      && sum[31] != exec_in.add_a[31];
   assign lres = exec_in.logic_result;
   assign a_exp = {ovf, sum[31], word == 32'h0, sum[32]};
   assign l_exp = {flags_out.ovf, lres[31], lres == 32'h0, flags_out.carry};
   assign fexc = {fp_in.indeterminate,
      fp_in.reserved_input | fp_in.reserved_result, fp_in.too_large,
      fp_in.too_small, fp_in.inexact,
      fp_in.is_divide & fp_in.divisor_zero & fp_in.dividend_nonzero_finite};
   assign fp_hit = fp_in.valid && (fexc & ~fmask_reg) != 6'h00;
   always_comb begin
      case (exec_in.check)
         alu_flag_pkg::CHECK_SIGNED: trap_exp = ovf;
         alu_flag_pkg::CHECK_UNS_ADD: trap_exp = sum[32];
         alu_flag_pkg::CHECK_UNS_SUB: trap_exp = !sum[32];
         default: trap_exp = 1'b0;
      endcase
      if (cls != alu_flag_pkg::CLASS_ARITH) begin
         trap_exp = cls == alu_flag_pkg::CLASS_MULDIV
            && exec_in.muldiv_op < alu_flag_pkg::signed_mulm_op
            && exec_in.mul_overflow && !mask_reg;
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         freeze_reg <= 1'b0;
         mask_reg <= 1'b0;
         fmask_reg <= 6'h00;
      end else if (wr_ok && avs_address == alu_flag_pkg::CONTROL_OFS) begin
         freeze_reg <= avs_writedata[0];
         mask_reg <= avs_writedata[1];
      end else if (wr_ok && avs_address == alu_flag_pkg::FP_ENV_OFS) begin
         fmask_reg <= avs_writedata[5:0];
      end
   end
   // ==========
   // assertions
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_bus_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer missing");
   a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer held too long");
   a_arith_flags: assert property (
      cls == alu_flag_pkg::CLASS_ARITH && !freeze_reg && !alu_wr
      |=> flags_out == $past(a_exp)) else $error("arith flags wrong");
   a_logic_flags: assert property (
      cls == alu_flag_pkg::CLASS_LOGICAL && !freeze_reg && !alu_wr
      |=> flags_out == $past(l_exp)) else $error("logic flags wrong");
   a_flags_hold: assert property (
      !alu_wr && (freeze_reg || cls == alu_flag_pkg::CLASS_NONE
      || cls == alu_flag_pkg::CLASS_MULDIV) |=> $stable(flags_out))
      else $error("flags changed");
   a_range_trap: assert property (
      1'b1 |=> range_trap == $past(trap_exp)) else $error("range trap wrong");
   a_trap_pc: assert property (
      trap_exp |=> pc2 == $past(exec_in.pc)) else $error("pc2 wrong");
   a_wb_word: assert property (
      cls == alu_flag_pkg::CLASS_ARITH |=> wb_valid && wb_data == $past(word))
      else $error("writeback wrong");
   a_fp_trap: assert property (
      1'b1 |=> fp_trap == $past(fp_hit)) else $error("fp trap wrong");
endmodule : alu_status_flag_checker

bind alu_status_flag_logic alu_status_flag_checker u_checker (
   .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_waitrequest(avs_waitrequest), .exec_in(exec_in), .fp_in(fp_in),
   .flags_out(flags_out), .wb_valid(wb_valid), .wb_data(wb_data),
   .range_trap(range_trap), .pc2(pc2), .fp_trap(fp_trap));

/* verification/alu_status_flag_logic_tb_top.sv */
// Purpose: self-checking bench for the status flag block
// Assumes: flags and pulses are seen the cycle after a request
// Notes:   random operands from a fixed seed plus corner values
`timescale 1ns/100ps
module alu_status_flag_logic_tb_top;
   logic core_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic wb_valid, range_trap, fp_trap;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, wb_data, d;
   logic [29:0] pc2;
   logic [3:0] ef;
   alu_flag_pkg::exec_type exec_in;
   alu_flag_pkg::fp_event_type fp_in;
   alu_flag_pkg::alu_flags_type flags_out;
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 4952;
   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;
   alu_status_flag_logic DUT (.core_clk(core_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .exec_in(exec_in), .fp_in(fp_in),
      .flags_out(flags_out), .wb_valid(wb_valid), .wb_data(wb_data),
      .range_trap(range_trap), .pc2(pc2), .fp_trap(fp_trap));
   exec_datapath_model src (.core_clk(core_clk), .ex(exec_in), .fp(fp_in));
   // ==========
   // helpers
   task automatic chk(input string n, input logic [31:0] seen,
         input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   task automatic bus(input logic wr, input logic [4:0] ad,
         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk);
      avs_address <= ad;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   function automatic logic [35:0] model(input logic [31:0] a,
         input logic [31:0] b, input logic sub, input logic step);
      logic [32:0] s;
      logic [31:0] bb, w;
      bb = sub ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + 33'(sub);
      w = step ? {s[30:0], 1'b0} : s[31:0];
      return {a[31] == bb[31] && s[31] != a[31], s[31], w == 32'h0, s[32], w};
   endfunction : model
   task automatic run_arith(input logic [31:0] a, input logic [31:0] b,
         input logic sub, input logic step,
         input alu_flag_pkg::range_check_type ck, input logic frz);
      logic [35:0] m;
      logic t;
      m = model(a, b, sub, step);
      t = (ck == alu_flag_pkg::CHECK_SIGNED && m[35])
         || (ck == alu_flag_pkg::CHECK_UNS_ADD && m[32])
         || (ck == alu_flag_pkg::CHECK_UNS_SUB && !m[32]);
      if (!frz) ef = m[35:32];
      src.arith(a, b, sub, step, ck);
      src.idle();
      chk("flags", 32'(flags_out), 32'(ef));
      chk("wb_data", wb_data, m[31:0]);
      chk("wb_valid", 32'(wb_valid), 32'h1);
      chk("range_trap", 32'(range_trap), 32'(t));
      if (t) chk("pc2", 32'(pc2), 32'(30'(a ^ b)));
   endtask : run_arith
   task automatic fp_case(input logic [5:0] x, input logic alt,
         input logic t, input logic [31:0] st);
      src.fpev(x, alt);
      src.idle();
      chk("fp_trap", 32'(fp_trap), 32'(t));
      bus(1'b0, alu_flag_pkg::FP_STATUS_OFS, 32'h0, d);
      chk("fp status", d, st);
   endtask : fp_case
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         end_sim();
      end
   end
   // ==========
   // main sequence
   initial begin
      int i, k;
      logic [31:0] a, ca [4];
      ca = '{32'h7FFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h80000000};
      ef = 4'h0;
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      for (i = 0; i < 7; i++) begin
         bus(1'b0, 5'(i * 4), 32'h0, d);
         chk("reset read", d, 32'h0);
      end
      $display("test reset done");
      for (i = 0; i < 44; i++) begin
         a = (i < 4) ? ca[i] : $random(seed);
         run_arith(a, (i < 4) ? 32'h1 : $random(seed),
            (i < 4) ? i[1] : 1'($random(seed)), i >= 4 && 1'($random(seed)),
            alu_flag_pkg::range_check_type'(i < 4 ? 2'(i + 1)
            : 2'($random(seed))), 1'b0);
      end
      run_arith(32'hFFFFFFFF, 32'h80000000, 1'b0, 1'b0,
         alu_flag_pkg::CHECK_NONE, 1'b0);
      $display("test arith done");
      for (i = 0; i < 6; i++) begin
         a = (i == 0) ? 32'h0 : $random(seed);
         ef = {ef[3], a[31], a == 32'h0, ef[0]};
         src.other(alu_flag_pkg::CLASS_LOGICAL, a, 3'h0, 1'b0);
         src.idle();
         chk("logic flags", 32'(flags_out), 32'(ef));
      end
      $display("test logical done");
      for (k = 0; k < 7; k++) begin
         if (k == 6) bus(1'b1, alu_flag_pkg::CONTROL_OFS, 32'h2, d);
         src.other(alu_flag_pkg::CLASS_MULDIV, $random(seed), 3'(k % 6), 1'b1);
         src.idle();
         chk("muldiv flags", 32'(flags_out), 32'(ef));
         chk("mul trap", 32'(range_trap), 32'(k < 2));
      end
      bus(1'b0, alu_flag_pkg::EXC_OPCODE_OFS, 32'h0, d);
      chk("exc opcode", d, 32'h11);
      $display("test muldiv done");
      bus(1'b1, alu_flag_pkg::CONTROL_OFS, 32'h1, d);
      for (i = 0; i < 4; i++) begin
         run_arith($random(seed), $random(seed), i[0], 1'b0,
            alu_flag_pkg::CHECK_SIGNED, 1'b1);
      end
      bus(1'b1, alu_flag_pkg::ALU_STATUS_OFS, 32'hA, d);
      bus(1'b0, alu_flag_pkg::ALU_STATUS_OFS, 32'h0, d);
      chk("frozen write", d, 32'hA);
      bus(1'b1, alu_flag_pkg::CONTROL_OFS, 32'h0, d);
      $display("test freeze done");
      bus(1'b1, alu_flag_pkg::FP_ENV_OFS, 32'h3F, d);
      for (k = 0; k < 6; k++) begin
         fp_case(6'(1 << k), k > 3, 1'b0, 32'((2 << k) - 1));
      end
      bus(1'b1, alu_flag_pkg::FP_ENV_OFS, 32'h1, d);
      fp_case(6'h06, 1'b0, 1'b1, 32'h063F);
      fp_case(6'h08, 1'b0, 1'b1, 32'h083F);
      fp_case(6'h01, 1'b0, 1'b0, 32'h083F);
      bus(1'b1, alu_flag_pkg::FP_STATUS_OFS, 32'h0, d);
      fp_case(6'h00, 1'b1, 1'b0, 32'h0);
      fp_case(6'h01, 1'b1, 1'b0, 32'h1);
      $display("test fp done");
      end_sim();
   end
endmodule : alu_status_flag_logic_tb_top

/* verification/exec_datapath_model.sv */
// Purpose: stand-in for the execution datapath and fp unit
// Assumes: requests change just after a rising clock edge
// Notes:   subtract adds the complement of the second operand
`timescale 1ns/100ps
module exec_datapath_model (
   input wire logic core_clk,
   output alu_flag_pkg::exec_type ex,
   output alu_flag_pkg::fp_event_type fp
);
   // ==========
   // request tasks
   initial begin
      ex = '0;
      fp = '0;
   end
   task automatic arith(input logic [31:0] a, input logic [31:0] b,
         input logic sub, input logic step,
         input alu_flag_pkg::range_check_type ck);
      alu_flag_pkg::exec_type e;
      e = '0;
      e.valid = 1'b1;
      e.op_class = alu_flag_pkg::CLASS_ARITH;
      e.check = ck;
      e.add_a = a;
      e.add_b = sub ? ~b : b;
      e.add_cin = sub;
      e.use_shift = step;
      e.shifted_result = (a + e.add_b + 32'(sub)) << 1;
      e.pc = 30'(a ^ b);
      @(posedge core_clk);
      ex <= e;
   endtask : arith
   task automatic other(input alu_flag_pkg::op_class_type c,
         input logic [31:0] r, input logic [2:0] k, input logic ovf);
      alu_flag_pkg::exec_type e;
      e = '0;
      e.valid = 1'b1;
      e.op_class = c;
      e.logic_result = r;
      e.muldiv_op = alu_flag_pkg::muldiv_op_type'(k);
      e.mul_overflow = ovf;
      e.opcode = 8'h10 + 8'(k);
      @(posedge core_clk);
      ex <= e;
   endtask : other
   task automatic fpev(input logic [5:0] x, input logic alt);
      @(posedge core_clk);
      fp <= {1'b1, alt | x[0], alt | x[0], x[0], x[1], x[2], x[3],
         x[4] & !alt, x[4] & alt, x[5]};
   endtask : fpev
   task automatic idle();
      @(posedge core_clk);
      ex.valid <= 1'b0;
      fp.valid <= 1'b0;
      @(negedge core_clk);
   endtask : idle
endmodule : exec_datapath_model
